/* File: logic/sfis_pkg.sv */
// constants, types and decode functions for the serial flash interface state block
// ============================================================================
// ============================================================================
package sfis_pkg;

    // ========================================================================
    // timing
    localparam int CLK_PERIOD_NS        = 25;
    localparam int POWER_UP_INTERVAL_US = 300;
    localparam int RESET_PULSE_TIME_NS  = 200;
    localparam int RESET_DURATION_US    = 35;
    localparam int RESET_HOLD_TIME_NS   = 50;
    // least times round up to whole cycles
    localparam int POWER_UP_CYC  = (POWER_UP_INTERVAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_DUR_CYC = (RESET_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_HOLD_CYC  = (RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 16;

    // ========================================================================
    // instruction codes and lengths
    localparam logic [7:0] OP_READ     = 8'h03;
    localparam logic [7:0] OP_FAST     = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_DUAL_IO  = 8'hBB;
    localparam logic [7:0] OP_QUAD_IO  = 8'hEB;
    localparam logic [7:0] OP_DDR_QIO  = 8'hED;
    localparam logic [7:0] OP_PROGRAM  = 8'h02;
    localparam logic [7:0] OP_WR_SCR   = 8'h01;
    localparam logic [7:0] OP_WR_ANY   = 8'h71;
    localparam logic [7:0] OP_WR_DLRN  = 8'h43;
    localparam logic [5:0] INSTR_BITS  = 6'h08;
    localparam logic [5:0] ADDR_BITS   = 6'h18;
    localparam logic [5:0] ADDR_MODE_BITS = 6'h20;
    localparam logic [2:0] LANES_1 = 3'h1;
    localparam logic [2:0] LANES_2 = 3'h2;
    localparam logic [2:0] LANES_4 = 3'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ========================================================================
    // interface states and transfer formats
    typedef enum logic [3:0] {
        ST_OFF = 4'b0000, ST_POR = 4'b0001, ST_HWRST = 4'b0010, ST_STBY = 4'b0011,
        ST_INSTR = 4'b0100, ST_SIN = 4'b0101, ST_DIN = 4'b0110, ST_QIN = 4'b0111,
        ST_LAT = 4'b1000, ST_OUT = 4'b1001
    } sfis_state_e;

    typedef enum logic [3:0] {
        FMT_NONE = 4'b0000, FMT_READ = 4'b0001, FMT_FAST = 4'b0010, FMT_DOUT = 4'b0011,
        FMT_QOUT = 4'b0100, FMT_DIO = 4'b0101, FMT_QIO = 4'b0110, FMT_DDR = 4'b0111,
        FMT_PROG = 4'b1000, FMT_WREG = 4'b1001
    } sfis_fmt_e;

    // instruction to transfer format
    function automatic sfis_fmt_e sfis_decode(input logic [7:0] op);
        case (op)
            OP_READ:     return FMT_READ;
            OP_FAST:     return FMT_FAST;
            OP_DUAL_OUT: return FMT_DOUT;
            OP_QUAD_OUT: return FMT_QOUT;
            OP_DUAL_IO:  return FMT_DIO;
            OP_QUAD_IO:  return FMT_QIO;
            OP_DDR_QIO:  return FMT_DDR;
            OP_PROGRAM:  return FMT_PROG;
            OP_WR_SCR, OP_WR_ANY, OP_WR_DLRN: return FMT_WREG;
            default:     return FMT_NONE;
        endcase
    endfunction

    // formats that return read data
    function automatic logic sfis_is_read(input sfis_fmt_e f);
        return (f >= FMT_READ) && (f <= FMT_DDR);
    endfunction

endpackage

/* File: logic/sfis_core.sv */
// serial flash interface state machine with its capture fifo
`timescale 1ns/1ps

// ============================================================================
// capture fifo: shift structure, output word always in slot 0
module sfis_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clocking
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int CW = $clog2(D + 1);
    logic [W-1:0]  mem [D];                     // storage, slot 0 is the head
    logic [CW-1:0] count;                       // words held
    logic [CW-1:0] next_count;
    wire           push = in_valid & in_ready;
    wire           pop  = out_valid & out_ready;

    assign next_count = count + CW'(push) - CW'(pop);
    assign out_data   = mem[0];

    // occupancy and flags, registered so the ports come from flops
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end
        else if (ce)
        begin
            count     <= next_count;
            in_ready  <= next_count != CW'(D);
            out_valid <= next_count != '0;
        end

    // each slot shifts down on pop, takes new data at the tail
    for (genvar i = 0; i < D; i++)
    begin : g_slot
        wire tail_pop  = push && (CW'(i + 1) == count);
        wire tail_hold = push && (CW'(i) == count);
        always_ff @(posedge sys_clk or negedge rst_b)
            if (!rst_b)
                mem[i] <= '0;
            else if (ce)
            begin
                if (pop)
                    mem[i] <= tail_pop ? in_data : ((i == D - 1) ? mem[i] : mem[(i + 1) % D]);
                else if (tail_hold)
                    mem[i] <= in_data;
            end
    end
endmodule

// ============================================================================
// device-side interface states
module sfis_core #(
    parameter int PU_CYCLES = sfis_pkg::POWER_UP_CYC
) (
    // clocking and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // supply monitor levels
    input  wire logic        vcc_above_low,
    input  wire logic        vcc_above_cutoff,
    // link pins
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        hw_reset_n,
    input  wire logic        serial_in_io0_in,
    output logic             serial_in_io0_out,
    output logic             serial_in_io0_oe,
    input  wire logic        serial_out_io1_in,
    output logic             serial_out_io1_out,
    output logic             serial_out_io1_oe,
    input  wire logic        wp_n_io2_in,
    output logic             wp_n_io2_out,
    output logic             wp_n_io2_oe,
    input  wire logic        io3_shared_reset_n_in,
    output logic             io3_shared_reset_n_out,
    output logic             io3_shared_reset_n_oe,
    // configuration
    input  wire logic        quad_enable_bit,
    input  wire logic        four_wire_instr_enable_bit,
    input  wire logic        io3_shared_reset_n_enable,
    input  wire logic [3:0]  latency_code_field,
    // read data from the array
    input  wire logic [7:0]  rd_byte,
    output logic             rd_byte_take,
    // captured byte stream
    output logic             cap_valid,
    output logic [7:0]       cap_data,
    input  wire logic        cap_ready,
    // status
    output sfis_pkg::sfis_state_e iface_state,
    output logic             cmd_done,
    output logic             cmd_rejected,
    output logic             wp_protect
);
    import sfis_pkg::*;

    // ========================================================================
    // constants
    localparam logic [TMR_W-1:0] PU_LAST  = TMR_W'(PU_CYCLES - 1);
    localparam logic [TMR_W-1:0] RPH_LAST = TMR_W'(RESET_DUR_CYC - 1);
    localparam logic [3:0]       RP_CNT   = 4'(RESET_PULSE_CYC);
    localparam logic [3:0]       RH_CNT   = 4'(RESET_HOLD_CYC);

    // ========================================================================
    // pin synchronisers
    logic [8:0]  pin_meta;                      // first stage, read only by pin_sync
    logic [8:0]  pin_sync;                      // second stage
    logic        cs_prev;                       // for edge detection
    logic        sck_prev;

    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            pin_meta <= 9'h1_F1;
            pin_sync <= 9'h1_F1;
            cs_prev  <= 1'b1;
            sck_prev <= 1'b0;
        end
        else if (ce)
        begin
            pin_meta <= {vcc_above_cutoff, vcc_above_low, hw_reset_n, io3_shared_reset_n_in,
                         wp_n_io2_in, serial_out_io1_in, serial_in_io0_in, sck, cs_n};
            pin_sync <= pin_meta;
            cs_prev  <= pin_sync[0];
            sck_prev <= pin_sync[1];
        end

    // named views of the synchronised pins
    wire       cs_hi     = pin_sync[0];
    wire       sck_s     = pin_sync[1];
    wire [3:0] io_s      = pin_sync[5:2];
    wire       hwr_n_s   = pin_sync[6];
    wire       v_low_ok  = pin_sync[7];
    wire       v_cut_ok  = pin_sync[8];
    wire       sck_rise  = sck_s & ~sck_prev;
    wire       sck_fall  = ~sck_s & sck_prev;
    wire       cs_rise   = cs_hi & ~cs_prev;
    wire       cs_fall   = ~cs_hi & cs_prev;

    // ========================================================================
    // state registers
    sfis_state_e     state;
    sfis_fmt_e       fmt;                       // format of the command in flight
    logic [TMR_W-1:0] timer;                    // power-up and reset duration
    logic [3:0]      rl_cnt;                    // cycles reset line seen low
    logic [3:0]      rh_cnt;                    // cycles reset line high after pulse
    logic [5:0]      cnt;                       // bits in current phase
    logic [2:0]      in_lanes;                  // input width
    logic [2:0]      out_lanes;                 // output width
    logic [7:0]      sh_in;                     // receive shifter
    logic [7:0]      out_sh;                    // transmit shifter
    logic [3:0]      out_left;                  // bits left in out_sh
    logic [3:0]      lat_cnt;                   // latency cycles done
    logic            bad;                       // command must be discarded
    logic [3:0]      io_out;
    logic [3:0]      io_oe;

    assign iface_state            = state;
    assign serial_in_io0_out      = io_out[0];
    assign serial_out_io1_out     = io_out[1];
    assign wp_n_io2_out           = io_out[2];
    assign io3_shared_reset_n_out = io_out[3];
    assign serial_in_io0_oe       = io_oe[0];
    assign serial_out_io1_oe      = io_oe[1];
    assign wp_n_io2_oe            = io_oe[2];
    assign io3_shared_reset_n_oe  = io_oe[3];

    // ========================================================================
    // reset line qualification
    wire quad_mode   = quad_enable_bit | four_wire_instr_enable_bit;
    // shared line only counts outside quad, or in quad while deselected
    wire io3_rst_low = io3_shared_reset_n_enable & ~io_s[3] & (~quad_mode | cs_hi);
    wire rst_low     = ~hwr_n_s | io3_rst_low;
    wire rst_hit     = rl_cnt == RP_CNT;

    // low-pulse and hold counters, both saturate
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            rl_cnt <= '0;
            rh_cnt <= '0;
        end
        else if (ce)
        begin
            rl_cnt <= !rst_low ? 4'h0 : (rst_hit ? rl_cnt : rl_cnt + 4'h1);
            rh_cnt <= rst_low ? 4'h0 : ((rh_cnt == RH_CNT) ? rh_cnt : rh_cnt + 4'h1);
        end

    // ========================================================================
    // receive path decode
    wire        rx_state  = (state == ST_INSTR) | (state == ST_SIN) |
                            (state == ST_DIN) | (state == ST_QIN);
    // lane 0 only in single mode, io1 never sampled as data there
    wire [7:0]  next_sh_in = (in_lanes == LANES_1) ? {sh_in[6:0], io_s[0]} :
                             (in_lanes == LANES_2) ? {sh_in[5:0], io_s[1:0]} :
                                                     {sh_in[3:0], io_s};
    wire [5:0]  next_cnt  = cnt + {3'h0, in_lanes};
    wire        byte_done = next_cnt[2:0] == 3'h0;
    wire        instr_end = (state == ST_INSTR) && (next_cnt == INSTR_BITS);
    sfis_fmt_e  instr_fmt;
    assign instr_fmt = sfis_decode(next_sh_in);
    wire        wide_addr = (fmt == FMT_DIO) | (fmt == FMT_QIO) | (fmt == FMT_DDR);
    wire [5:0]  addr_len  = wide_addr ? ADDR_MODE_BITS : ADDR_BITS;
    wire        phase_end = rx_state && (state != ST_INSTR) && sfis_is_read(fmt) &&
                            (next_cnt == addr_len);
    wire        lat_zero  = (fmt == FMT_READ) | (latency_code_field == 4'h0);
    wire        fifo_ready;
    wire        push      = rx_state & sck_rise & byte_done & ~cs_rise;

    // lane widths for the decoded instruction
    wire        i_qpi     = four_wire_instr_enable_bit;
    wire [2:0]  i_in_l    = i_qpi ? LANES_4 :
                            (instr_fmt == FMT_DIO) ? LANES_2 :
                            ((instr_fmt == FMT_QIO) | (instr_fmt == FMT_DDR)) ? LANES_4 : LANES_1;
    wire [2:0]  i_out_l   = i_qpi ? LANES_4 :
                            ((instr_fmt == FMT_DOUT) | (instr_fmt == FMT_DIO)) ? LANES_2 :
                            ((instr_fmt == FMT_READ) | (instr_fmt == FMT_FAST)) ? LANES_1 : LANES_4;
    sfis_state_e i_next;
    assign i_next = (i_in_l == LANES_1) ? ST_SIN : ((i_in_l == LANES_2) ? ST_DIN : ST_QIN);

    // ========================================================================
    // transmit path decode
    wire [7:0]  drv_src  = (out_left == 4'h0) ? rd_byte : out_sh;
    wire [3:0]  drv_bits = (out_lanes == LANES_1) ? {2'b00, drv_src[7], 1'b0} :
                           (out_lanes == LANES_2) ? {2'b00, drv_src[7:6]} : drv_src[7:4];
    wire [3:0]  drv_oe   = (out_lanes == LANES_1) ? 4'h2 :
                           (out_lanes == LANES_2) ? 4'h3 : 4'hF;
    wire [7:0]  drv_sh   = drv_src << out_lanes;
    wire [3:0]  drv_left = ((out_left == 4'h0) ? BYTE_BITS : out_left) - {1'b0, out_lanes};
    // partial byte in any receive state is refused, read commands included
    wire        reject   = bad | (rx_state & (cnt[2:0] != 3'h0));
    wire        empty    = (state == ST_INSTR) & (cnt == 6'h0);
    wire        active   = rx_state | (state == ST_LAT) | (state == ST_OUT);

    // ========================================================================
    // interface state machine
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            state <= ST_OFF;  fmt <= FMT_NONE;  timer <= '0;  cnt <= '0;
            in_lanes <= LANES_1;  out_lanes <= LANES_1;  sh_in <= '0;  out_sh <= '0;
            out_left <= '0;  lat_cnt <= '0;  bad <= 1'b0;  io_out <= '0;  io_oe <= '0;
            cmd_done <= 1'b0;  cmd_rejected <= 1'b0;  rd_byte_take <= 1'b0;  wp_protect <= 1'b0;
        end
        else if (ce)
        begin
            cmd_done     <= 1'b0;
            cmd_rejected <= 1'b0;
            rd_byte_take <= 1'b0;
            // power gone: silent, nothing runs
            if (!v_low_ok)
            begin
                state <= ST_OFF;
                io_oe <= 4'h0;
            end
            // reset pulse wins over any command
            else if (rst_hit && state != ST_OFF && state != ST_POR && state != ST_HWRST)
            begin
                state <= ST_HWRST;
                timer <= '0;
                io_oe <= 4'h0;
            end
            // deselect ends any command and frees the lines
            else if (active && cs_rise)
            begin
                state        <= ST_STBY;
                io_oe        <= 4'h0;
                cmd_rejected <= ~empty & reject;
                cmd_done     <= ~empty & ~reject;
            end
            else
            begin
                if (active && !v_cut_ok)
                    bad <= 1'b1;
                unique case (state)
                    ST_OFF:
                    begin
                        state <= ST_POR;
                        timer <= '0;
                    end
                    // inputs ignored, outputs released for the whole interval
                    ST_POR:
                    begin
                        timer <= timer + 1'b1;
                        if (timer == PU_LAST)
                            state <= ST_STBY;
                    end
                    // leave after duration and hold, whichever comes last
                    ST_HWRST:
                    begin
                        if (timer != RPH_LAST)
                            timer <= timer + 1'b1;
                        else if (rh_cnt == RH_CNT)
                            state <= ST_STBY;
                    end
                    // only chip select, the supply levels, reset and four_wire_instr_enable_bit are looked at here
                    ST_STBY:
                    begin
                        if (cs_fall && v_cut_ok)
                        begin
                            state      <= ST_INSTR;
                            cnt        <= '0;
                            bad        <= 1'b0;
                            wp_protect <= 1'b0;
                            in_lanes   <= i_qpi ? LANES_4 : LANES_1;
                        end
                    end
                    ST_INSTR, ST_SIN, ST_DIN, ST_QIN:
                    begin
                        if (sck_rise)
                        begin
                            sh_in <= next_sh_in;
                            cnt   <= next_cnt;
                            if (push && !fifo_ready)
                                bad <= 1'b1;
                            if (instr_end)
                            begin
                                fmt       <= instr_fmt;
                                cnt       <= '0;
                                in_lanes  <= i_in_l;
                                out_lanes <= i_out_l;
                                state     <= i_next;
                                // write-protect only matters for register writes
                                wp_protect <= (instr_fmt == FMT_WREG) & ~i_qpi & ~io_s[2];
                            end
                            else if (phase_end)
                            begin
                                lat_cnt  <= '0;
                                out_left <= '0;
                                state    <= lat_zero ? ST_OUT : ST_LAT;
                            end
                        end
                    end
                    // dummy cycles counted on rising edges
                    ST_LAT:
                    begin
                        if (sck_rise)
                        begin
                            lat_cnt <= lat_cnt + 4'h1;
                            if (lat_cnt + 4'h1 == latency_code_field)
                                state <= ST_OUT;
                        end
                    end
                    // data changes on falling edges, latency already ended on a rising edge
                    ST_OUT:
                    begin
                        if (sck_fall)
                        begin
                            io_out       <= drv_bits;
                            io_oe        <= drv_oe;
                            out_sh       <= drv_sh;
                            out_left     <= drv_left;
                            rd_byte_take <= out_left == 4'h0;
                        end
                    end
                    default:
                        state <= ST_STBY;
                endcase
            end
        end

    // ========================================================================
    // every received byte goes out through the fifo; full stream marks the command bad
    sfis_fifo #(
        .W (8),
        .D (8)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .in_valid  (push),
        .in_data   (next_sh_in),
        .in_ready  (fifo_ready),
        .out_valid (cap_valid),
        .out_data  (cap_data),
        .out_ready (cap_ready)
    );
endmodule

/* File: bench/sfis_core_properties.sv */
// checker for the interface state block
`timescale 1ns/1ps
module sfis_core_properties import sfis_pkg::*; (
    input wire logic sys_clk, rst_b, cs_n, hw_reset_n, vcc_above_cutoff, cmd_done,
    input wire logic serial_in_io0_oe, serial_out_io1_oe, rd_byte_take,
    input sfis_state_e iface_state
);
    logic [15:0] hw_cnt; // cycles spent in hardware reset
    wire idle = iface_state inside {ST_OFF, ST_POR, ST_HWRST, ST_STBY};
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b) hw_cnt <= '0;
        else hw_cnt <= (iface_state == ST_HWRST) ? hw_cnt + 16'h0001 : '0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_hw_exit; iface_state == ST_HWRST ##1 iface_state == ST_STBY; endsequence
    sequence s_instr; $rose(iface_state == ST_INSTR); endsequence
    property p_hw_exit; s_hw_exit |-> hw_reset_n && $past(hw_cnt) >= RESET_DUR_CYC - 2; endproperty
    property p_idle; $stable(iface_state) && idle |-> !serial_out_io1_oe && !serial_in_io0_oe; endproperty
    property p_in; iface_state inside {ST_INSTR, ST_SIN} |-> !serial_out_io1_oe; endproperty
    property p_cs; cs_n [*6] |-> idle; endproperty
    property p_entry; s_instr |-> $past(iface_state) == ST_STBY && !cs_n; endproperty
    property p_cut; !vcc_above_cutoff [*6] |-> !cmd_done; endproperty
    property p_take; rd_byte_take |-> iface_state == ST_OUT; endproperty
    property p_done; cmd_done |-> ##[0:2] iface_state == ST_STBY; endproperty
    a_hw_exit: assert property (p_hw_exit) else $error("early reset exit");
    a_idle: assert property (p_idle) else $error("idle drive");
    a_in: assert property (p_in) else $error("input drive");
    a_cs: assert property (p_cs) else $error("no standby");
    a_entry: assert property (p_entry) else $error("bad entry");
    a_cut: assert property (p_cut) else $error("low supply cmd");
    a_take: assert property (p_take) else $error("early take");
    a_done: assert property (p_done) else $error("no return");
endmodule
bind sfis_core sfis_core_properties chk (.*);

/* File: bench/sfis_host.sv */
// host model: select, clock stands low between frames
`timescale 1ns/1ps
module sfis_host (
    input  wire logic sys_clk, io1,
    output logic      cs_n = 1'b1, sck = 1'b0, io0 = 1'b0,
    output logic      io3 = 1'b1
);
    logic [31:0] r; // serial output seen before each rise
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic shift(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            io0 <= v[i];
            tick(4);
            r = {r[30:0], io1};
            sck <= 1'b1;
            tick(4);
            sck <= 1'b0;
        end
    endtask
    // deselect only after the last rise has landed
    task automatic desel;
        tick(4);
        cs_n <= 1'b1;
        tick(8);
    endtask
endmodule

/* File: bench/tb.sv */
// top-level bench: host model, block and scenarios
`timescale 1ns/1ps
module tb;
    import sfis_pkg::*;
    logic sys_clk = 0, rst_b = 0, ce = 1, vcc_above_low = 1, vcc_above_cutoff = 1;
    logic hw_reset_n = 1, wp_n_io2_in = 1, cap_ready = 1, io1_q = 0, hit_d = 0, hit_r = 0;
    logic quad_enable_bit = 0, four_wire_instr_enable_bit = 0, io3_shared_reset_n_enable = 0;
    logic [3:0] latency_code_field = 4'h0;
    logic [7:0] rd_byte = 8'hA5, cap_data;
    logic cs_n, sck, serial_in_io0_in, serial_in_io0_out, serial_in_io0_oe, serial_out_io1_out;
    logic serial_out_io1_oe, wp_n_io2_out, wp_n_io2_oe, io3_shared_reset_n_in, cmd_rejected;
    logic io3_shared_reset_n_out, io3_shared_reset_n_oe, rd_byte_take, cap_valid, cmd_done;
    logic wp_protect;
    sfis_state_e iface_state;
    int n_mismatch = 0, checked = 0, cyc = 0, pops = 0;
    // a released output line toggles so stale data never matches
    wire serial_out_io1_in = serial_out_io1_oe ? serial_out_io1_out : ~io1_q;
    sfis_host h (.sys_clk(sys_clk), .io1(serial_out_io1_in), .cs_n(cs_n), .sck(sck),
        .io0(serial_in_io0_in), .io3(io3_shared_reset_n_in));
    sfis_core #(.PU_CYCLES(20)) dut (.*);
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        io1_q <= serial_out_io1_in;
        hit_d <= hit_d | cmd_done;
        hit_r <= hit_r | cmd_rejected;
        pops <= pops + int'(cap_valid && cap_ready);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            complete_run;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [31:0] v, input int n);
        hit_d = 0;
        hit_r = 0;
        h.cs_n <= 1'b0;
        h.tick(4);
        h.shift(v, n);
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_power;
        h.tick(10);
        chk(iface_state, ST_POR);
        h.tick(40);
        chk(iface_state, ST_STBY);
        vcc_above_low = 0;
        h.tick(4);
        chk(iface_state, ST_OFF);
        vcc_above_low = 1;
        h.tick(40);
        chk(iface_state, ST_STBY);
    endtask
    task automatic t_read;
        cmd({OP_READ, 24'h00_0100}, 32);
        chk(iface_state, ST_OUT);
        h.shift(0, 8);
        chk(h.r[7:0], rd_byte);
        h.desel;
        chk({hit_d, serial_out_io1_oe, iface_state}, {2'b10, ST_STBY});
    endtask
    task automatic t_short;
        cmd(8'h06, 8);
        h.desel;
        chk(hit_d, 1);
        cmd(0, 5);
        h.desel;
        chk(hit_r, 1);
    endtask
    task automatic t_wp;
        wp_n_io2_in = 0;
        cmd(OP_WR_SCR, 8);
        h.desel;
        chk(wp_protect, 1);
        cmd(OP_FAST, 8);
        h.desel;
        chk(wp_protect, 0);
        wp_n_io2_in = 1;
    endtask
    task automatic t_cut;
        vcc_above_cutoff = 0;
        h.tick(8);
        cmd(8'h06, 8);
        chk(iface_state, ST_STBY);
        h.desel;
        chk(hit_d, 0);
        vcc_above_cutoff = 1;
    endtask
    task automatic t_fifo;
        cap_ready = 0;
        cmd({OP_PROGRAM, 24'h00_0000}, 32);
        h.shift(0, 32);
        h.shift(0, 16);
        h.desel;
        chk(hit_r, 1);
        cap_ready = 1;
        h.tick(20);
        chk(pops, 15);
    endtask
    task automatic t_lat;
        latency_code_field = 4'h2;
        rd_byte = 8'h3C;
        cmd({OP_FAST, 24'h00_0000}, 32);
        chk(iface_state, ST_LAT);
        h.shift(0, 2);
        chk({serial_out_io1_oe, iface_state}, {1'b0, ST_OUT});
        h.shift(0, 8);
        chk(h.r[7:0], 8'h3C);
        h.desel;
    endtask
    task automatic t_quad;
        four_wire_instr_enable_bit = 1;
        cmd(0, 1);
        chk(iface_state, ST_INSTR);
        h.shift(0, 1);
        chk(iface_state, ST_QIN);
        h.desel;
        four_wire_instr_enable_bit = 0;
        io3_shared_reset_n_enable = 1;
        quad_enable_bit = 1;
        cmd(8'h06, 8);
        h.io3 <= 0;
        h.tick(16);
        chk(iface_state, ST_SIN);
        h.io3 <= 1;
        h.desel;
        h.io3 <= 0;
        h.tick(16);
        h.io3 <= 1;
        chk(iface_state, ST_HWRST);
        h.tick(1450);
        chk(iface_state, ST_STBY);
    endtask
    task automatic t_hwrst;
        hw_reset_n = 0;
        h.tick(16);
        hw_reset_n = 1;
        chk(iface_state, ST_HWRST);
        h.tick(1300);
        chk(iface_state, ST_HWRST);
        h.tick(150);
        chk(iface_state, ST_STBY);
    endtask
    initial
    begin
        h.tick(5);
        rst_b = 1;
        t_power;
        t_read;
        t_short;
        t_wp;
        t_cut;
        t_fifo;
        t_lat;
        t_quad;
        t_hwrst;
        complete_run;
    end
endmodule
